/* rtl/special_reg_and_hint_exec.sv */
// Executes special register moves and hint/system instructions, with an APB
// control and interrupt block. Assumes one instruction offered at a time and
// APB signals synchronous to clk.
`timescale 1ns/100ps
module special_reg_and_hint_exec (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [sr_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic instr_valid,
   output logic instr_ready,
   input wire sr_pkg::op_e instr_op,
   input wire sr_pkg::sel_e instr_sel,
   input wire logic [1:0] instr_app_mask,
   input wire logic instr_priv,
   input wire logic [31:0] instr_src,
   output logic instr_done,
   output logic [31:0] rd_data,
   output logic event_out,
   output logic super_call,
   output logic suspended,
   input wire logic exc_above_prio,
   input wire logic pend_new,
   input wire logic debug_req,
   input wire logic ext_event,
   input wire logic irq_taken,
   input wire logic masked_pending,
   output logic [sr_pkg::FLAG_W-1:0] cond_flags,
   output logic interrupt_mask_bit,
   output logic [sr_pkg::PRIO_W-1:0] base_priority_mask,
   output logic fault_mask
);
   localparam int PW = sr_pkg::PRIO_W;

   // Raise-only rule for the base priority alias write
   function automatic logic raise_ok(input logic [PW-1:0] src, input logic [PW-1:0] cur);
      raise_ok = (src != '0) && ((cur == '0) || (src < cur));
   endfunction

   // Status view: only flags and GE bits exist, rest reads zero
   function automatic logic [31:0] psr_view(input logic [sr_pkg::FLAG_W-1:0] f,
                                            input logic [sr_pkg::GE_W-1:0] g);
      logic [31:0] v;
      v = 32'h0;
      v[sr_pkg::FLAG_LSB +: sr_pkg::FLAG_W] = f;
      v[sr_pkg::GE_LSB +: sr_pkg::GE_W] = g;
      psr_view = v;
   endfunction

   wait_if w (); // Link to the suspension controller

   // Special registers
   logic [sr_pkg::FLAG_W-1:0] flags_r, flags_nxt; // N Z C V Q
   logic [sr_pkg::GE_W-1:0] ge_r, ge_nxt; // Greater-or-equal bits
   logic [31:0] msp_r, msp_nxt; // Main stack pointer
   logic [31:0] psp_r, psp_nxt; // Process stack pointer
   logic imask_r, imask_nxt; // Interrupt mask bit
   logic [PW-1:0] base_r, base_nxt; // Base priority mask
   logic fmask_r, fmask_nxt; // Fault mask
   logic [sr_pkg::CTRL_W-1:0] ctl_r, ctl_nxt; // Control register
   // Instruction results
   logic [31:0] rd_r, rd_nxt; // Read result
   logic done_r, done_nxt; // Completion of single-cycle ops
   logic sev_r, sev_nxt; // Broadcast event pulse
   logic call_r, call_nxt; // Supervisor call pulse
   logic refused; // Privilege refusal this cycle
   logic acc; // Instruction accepted

   // A wait occupies the issue slot until it resumes
   assign instr_ready = !w.sleeping;
   assign acc = instr_valid && instr_ready;

   // Instruction execution, next values
   always_comb begin
      flags_nxt = flags_r;
      ge_nxt = ge_r;
      msp_nxt = msp_r;
      psp_nxt = psp_r;
      imask_nxt = imask_r;
      base_nxt = base_r;
      fmask_nxt = fmask_r;
      ctl_nxt = ctl_r;
      rd_nxt = rd_r;
      done_nxt = 1'b0;
      sev_nxt = 1'b0;
      call_nxt = 1'b0;
      refused = 1'b0;
      if (acc) begin
         case (instr_op)
            sr_pkg::OP_READ_SR: begin
               done_nxt = 1'b1;
               case (instr_sel)
                  // All status views hide exception and state fields
                  sr_pkg::SEL_APP, sr_pkg::SEL_EXC, sr_pkg::SEL_EXE, sr_pkg::SEL_EXC_EXE,
                  sr_pkg::SEL_EXC_APP, sr_pkg::SEL_EXE_APP, sr_pkg::SEL_ALL: begin
                     rd_nxt = psr_view(flags_r, ge_r);
                  end
                  sr_pkg::SEL_MAIN_SP: rd_nxt = msp_r;
                  sr_pkg::SEL_PROC_SP: rd_nxt = psp_r;
                  sr_pkg::SEL_INT_MASK: rd_nxt = {31'h0, imask_r};
                  sr_pkg::SEL_BASE, sr_pkg::SEL_BASE_RAISE: begin
                     rd_nxt = {{(32-PW){1'b0}}, base_r};
                  end
                  sr_pkg::SEL_FAULT_MASK: rd_nxt = {31'h0, fmask_r};
                  sr_pkg::SEL_CONTROL: rd_nxt = {{(32-sr_pkg::CTRL_W){1'b0}}, ctl_r};
                  default: rd_nxt = 32'h0;
               endcase
            end
            sr_pkg::OP_WRITE_SR: begin
               done_nxt = 1'b1;
               if (!instr_priv && instr_sel != sr_pkg::SEL_APP) begin
                  // Unprivileged code may only touch the app view
                  refused = 1'b1;
               end else begin
                  case (instr_sel)
                     sr_pkg::SEL_APP: begin
                        // Only the flag and GE lanes are stored; other bits are dropped
                        if (instr_app_mask[sr_pkg::APPM_FLAGS]) begin
                           flags_nxt = instr_src[sr_pkg::FLAG_LSB +: sr_pkg::FLAG_W];
                        end
                        if (instr_app_mask[sr_pkg::APPM_GE]) begin
                           ge_nxt = instr_src[sr_pkg::GE_LSB +: sr_pkg::GE_W];
                        end
                     end
                     // Stack pointers are word aligned
                     sr_pkg::SEL_MAIN_SP: msp_nxt = {instr_src[31:2], 2'b00};
                     sr_pkg::SEL_PROC_SP: psp_nxt = {instr_src[31:2], 2'b00};
                     sr_pkg::SEL_INT_MASK: imask_nxt = instr_src[0];
                     sr_pkg::SEL_BASE: base_nxt = instr_src[PW-1:0];
                     sr_pkg::SEL_BASE_RAISE: begin
                        if (raise_ok(instr_src[PW-1:0], base_r)) begin
                           base_nxt = instr_src[PW-1:0];
                        end
                     end
                     sr_pkg::SEL_FAULT_MASK: fmask_nxt = instr_src[0];
                     sr_pkg::SEL_CONTROL: ctl_nxt = instr_src[sr_pkg::CTRL_W-1:0];
                     // Other status views are read-only
                     default: refused = 1'b0;
                  endcase
               end
            end
            sr_pkg::OP_SEND_EVENT: begin
               done_nxt = 1'b1;
               sev_nxt = 1'b1;
            end
            sr_pkg::OP_SUPER_CALL: begin
               // Immediate stays in the instruction for the handler
               done_nxt = 1'b1;
               call_nxt = 1'b1;
            end
            // Waits complete through the suspension controller
            sr_pkg::OP_WAIT_EVENT, sr_pkg::OP_WAIT_INT: done_nxt = 1'b0;
            // No-operation retires with no state change
            default: done_nxt = 1'b1;
         endcase
      end
   end

   // Instruction state registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         flags_r <= '0;
         ge_r <= '0;
         msp_r <= 32'h0;
         psp_r <= 32'h0;
         imask_r <= 1'b0;
         base_r <= '0;
         fmask_r <= 1'b0;
         ctl_r <= '0;
         rd_r <= 32'h0;
         done_r <= 1'b0;
         sev_r <= 1'b0;
         call_r <= 1'b0;
      end else begin
         flags_r <= flags_nxt;
         ge_r <= ge_nxt;
         msp_r <= msp_nxt;
         psp_r <= psp_nxt;
         imask_r <= imask_nxt;
         base_r <= base_nxt;
         fmask_r <= fmask_nxt;
         ctl_r <= ctl_nxt;
         rd_r <= rd_nxt;
         done_r <= done_nxt;
         sev_r <= sev_nxt;
         call_r <= call_nxt;
      end
   end

   // APB control and interrupt state
   logic [1:0] cfg_r, cfg_nxt; // Wake-on-pending and debug enable
   logic [sr_pkg::IRQ_W-1:0] ist_r, ist_nxt; // Sticky event status
   logic [sr_pkg::IRQ_W-1:0] imsk_r, imsk_nxt; // Interrupt mask
   logic [31:0] prd_r, prd_nxt; // Read data, loaded in setup
   logic err_r, err_nxt; // Unmapped address flag
   logic [sr_pkg::IRQ_W-1:0] ev; // Events this cycle
   logic wr_acc; // APB write access phase

   // Wait controller hookup; event-wait wake terms pend_new and debug_req gated by software settings
   assign w.wait_ev_go = acc && instr_op == sr_pkg::OP_WAIT_EVENT;
   assign w.wait_int_go = acc && instr_op == sr_pkg::OP_WAIT_INT;
   assign w.ev_set = sev_nxt || ext_event;
   assign w.wake_ev = exc_above_prio || (pend_new && cfg_r[sr_pkg::CTRL_WAKE_PEND])
                      || (debug_req && cfg_r[sr_pkg::CTRL_DBG_EN]) || ext_event;
   assign w.wake_int = irq_taken || masked_pending || debug_req;

   assign ev = {refused, w.done, sev_r, call_r};
   assign wr_acc = psel && penable && pwrite;

   // Register file next values; a new event beats a clearing write
   always_comb begin
      cfg_nxt = cfg_r;
      imsk_nxt = imsk_r;
      ist_nxt = ist_r | ev;
      prd_nxt = prd_r;
      err_nxt = err_r;
      if (wr_acc && !err_r) begin
         if (paddr == sr_pkg::ADDR_CTRL) begin
            cfg_nxt = pwdata[1:0];
         end else if (paddr == sr_pkg::ADDR_IRQ_ST) begin
            ist_nxt = (ist_r & ~pwdata[sr_pkg::IRQ_W-1:0]) | ev;
         end else if (paddr == sr_pkg::ADDR_IRQ_MASK) begin
            imsk_nxt = pwdata[sr_pkg::IRQ_W-1:0];
         end
      end
      if (psel && !penable) begin
         err_nxt = 1'b0;
         prd_nxt = 32'h0;
         if (paddr == sr_pkg::ADDR_CTRL) begin
            prd_nxt[1:0] = cfg_r;
         end else if (paddr == sr_pkg::ADDR_STATE) begin
            prd_nxt[sr_pkg::STB_SUSP] = w.sleeping;
            prd_nxt[sr_pkg::STB_EVENT] = w.event_reg;
            prd_nxt[sr_pkg::STB_INT_MASK] = imask_r;
            prd_nxt[sr_pkg::STB_FAULT_MASK] = fmask_r;
            prd_nxt[sr_pkg::STB_BASE_LSB +: PW] = base_r;
            prd_nxt[sr_pkg::STB_CTRL_LSB +: sr_pkg::CTRL_W] = ctl_r;
         end else if (paddr == sr_pkg::ADDR_IRQ_ST) begin
            prd_nxt[sr_pkg::IRQ_W-1:0] = ist_r;
         end else if (paddr == sr_pkg::ADDR_IRQ_MASK) begin
            prd_nxt[sr_pkg::IRQ_W-1:0] = imsk_r;
         end else begin
            err_nxt = 1'b1;
         end
      end
   end

   // Register file flops
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cfg_r <= sr_pkg::RST_CTRL;
         ist_r <= '0;
         imsk_r <= sr_pkg::RST_IRQ_MASK;
         prd_r <= 32'h0;
         err_r <= 1'b0;
      end else begin
         cfg_r <= cfg_nxt;
         ist_r <= ist_nxt;
         imsk_r <= imsk_nxt;
         prd_r <= prd_nxt;
         err_r <= err_nxt;
      end
   end

   wait_ctl u_wait (
      .clk(clk),
      .rst_b(rst_b),
      .w(w.ctl)
   );

   // Outputs; zero-wait APB answer
   assign pready = 1'b1;
   assign prdata = prd_r;
   assign pslverr = psel && penable && err_r;
   assign irq = |(ist_r & imsk_r);
   assign instr_done = done_r || w.done;
   assign rd_data = rd_r;
   assign event_out = sev_r;
   assign super_call = call_r;
   assign suspended = w.sleeping;
   assign cond_flags = flags_r;
   assign interrupt_mask_bit = imask_r;
   assign base_priority_mask = base_r;
   assign fault_mask = fmask_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_wr(sr_pkg::sel_e s);
      acc && instr_op == sr_pkg::OP_WRITE_SR && instr_sel == s;
   endsequence

   property p_alias;
      acc && instr_op == sr_pkg::OP_READ_SR && instr_sel == sr_pkg::SEL_BASE_RAISE
      |=> rd_data == {24'h0, $past(base_r)} && instr_done;
   endproperty
   a_alias: assert property (p_alias) else $error("raise alias read wrong");

   property p_unpriv;
      acc && instr_op == sr_pkg::OP_WRITE_SR && !instr_priv && instr_sel != sr_pkg::SEL_APP
      |=> ($stable(base_r) && $stable(imask_r) && $stable(ctl_r)) ##1 ist_r[sr_pkg::IRQ_REFUSED];
   endproperty
   a_unpriv: assert property (p_unpriv) else $error("unprivileged write took effect");

   property p_raise_hold;
      s_wr(sr_pkg::SEL_BASE_RAISE) and !raise_ok(instr_src[PW-1:0], base_r) |=> $stable(base_r);
   endproperty
   a_raise_hold: assert property (p_raise_hold) else $error("raise write changed mask");

   property p_raise_upd;
      s_wr(sr_pkg::SEL_BASE_RAISE) and instr_priv and raise_ok(instr_src[PW-1:0], base_r)
      |=> base_r == $past(instr_src[PW-1:0]);
   endproperty
   a_raise_upd: assert property (p_raise_upd) else $error("raise write missed");

   property p_flags;
      s_wr(sr_pkg::SEL_APP) and instr_app_mask[sr_pkg::APPM_FLAGS]
      |=> flags_r == $past(instr_src[31:27]);
   endproperty
   a_flags: assert property (p_flags) else $error("flags not loaded");

   property p_psr_zero;
      acc && instr_op == sr_pkg::OP_READ_SR && instr_sel <= sr_pkg::SEL_ALL
      |=> rd_data[26:20] == 7'h0 && rd_data[15:0] == 16'h0;
   endproperty
   a_psr_zero: assert property (p_psr_zero) else $error("status view leaked fields");

   property p_nop;
      acc && instr_op == sr_pkg::OP_NOP |=> instr_done && $stable(base_r) && $stable(flags_r);
   endproperty
   a_nop: assert property (p_nop) else $error("no-op had effect");

   property p_send;
      acc && instr_op == sr_pkg::OP_SEND_EVENT |=> event_out ##1 w.event_reg;
   endproperty
   a_send: assert property (p_send) else $error("send event missing");

   property p_call;
      acc && instr_op == sr_pkg::OP_SUPER_CALL
      |=> super_call ##1 (!super_call || $past(acc && instr_op == sr_pkg::OP_SUPER_CALL));
   endproperty
   a_call: assert property (p_call) else $error("supervisor call not raised");

   property p_keep;
      suspended |=> $stable(base_r) && $stable(msp_r) && $stable(imask_r);
   endproperty
   a_keep: assert property (p_keep) else $error("register changed while suspended");
endmodule

/* rtl/sr_pkg.sv */
// Shared constants and types for the special register and hint executor.
// Assumes one 20 MHz core clock; register offsets are byte addresses on APB.
package sr_pkg;
   // Instruction kinds presented by the issue stage
   typedef enum logic [2:0] {
      OP_NOP, OP_READ_SR, OP_WRITE_SR, OP_SEND_EVENT, OP_SUPER_CALL, OP_WAIT_EVENT, OP_WAIT_INT
   } op_e;
   // Special register selector
   typedef enum logic [3:0] {
      SEL_APP, SEL_EXC, SEL_EXE, SEL_EXC_EXE, SEL_EXC_APP, SEL_EXE_APP, SEL_ALL,
      SEL_MAIN_SP, SEL_PROC_SP, SEL_INT_MASK, SEL_BASE, SEL_BASE_RAISE, SEL_FAULT_MASK, SEL_CONTROL
   } sel_e;
   // Status word layout
   localparam int FLAG_LSB = 27;
   localparam int FLAG_W = 5;
   localparam int GE_LSB = 16;
   localparam int GE_W = 4;
   localparam int PRIO_W = 8;
   localparam int CTRL_W = 2;
   // Write lane selectors for the app status view
   localparam int APPM_FLAGS = 0;
   localparam int APPM_GE = 1;
   // APB map
   localparam int APB_AW = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATE = 8'h04;
   localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
   // Control register fields
   localparam int CTRL_WAKE_PEND = 0;
   localparam int CTRL_DBG_EN = 1;
   localparam logic [1:0] RST_CTRL = 2'h0;
   // State register fields
   localparam int STB_SUSP = 0;
   localparam int STB_EVENT = 1;
   localparam int STB_INT_MASK = 2;
   localparam int STB_FAULT_MASK = 3;
   localparam int STB_BASE_LSB = 8;
   localparam int STB_CTRL_LSB = 16;
   // Interrupt status bits
   localparam int IRQ_W = 4;
   localparam int IRQ_SUPER = 0;
   localparam int IRQ_EVENT = 1;
   localparam int IRQ_WAIT_DONE = 2;
   localparam int IRQ_REFUSED = 3;
   localparam logic [3:0] RST_IRQ_MASK = 4'h0;
endpackage

/* rtl/wait_if.sv */
// Link between the executor and its suspension controller.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface wait_if;
   logic wait_ev_go; // Wait-for-event accepted
   logic wait_int_go; // Wait-for-interrupt accepted
   logic ev_set; // Event register set source
   logic wake_ev; // Wake terms for event wait
   logic wake_int; // Wake terms for interrupt wait
   logic done; // Wait instruction completed
   logic sleeping; // Execution suspended
   logic event_reg; // Local event register
   modport core (output wait_ev_go, wait_int_go, ev_set, wake_ev, wake_int,
                 input done, sleeping, event_reg);
   modport ctl (input wait_ev_go, wait_int_go, ev_set, wake_ev, wake_int,
                output done, sleeping, event_reg);
endinterface

/* rtl/wait_ctl.sv */
// Suspension controller: local event register and the two wait states.
// Assumes go strobes only arrive while not sleeping.
`timescale 1ns/100ps
module wait_ctl (
   input wire logic clk,
   input wire logic rst_b,
   wait_if.ctl w
);
   typedef enum logic [1:0] {ST_RUN, ST_WAIT_EV, ST_WAIT_INT} wstate_e;
   wstate_e state_r, state_nxt; // Suspension state
   logic event_r, event_nxt; // Local event register
   logic done_r, done_nxt; // Completion pulse

   // Next state; a set arriving with a clear wins
   always_comb begin
      state_nxt = state_r;
      event_nxt = event_r | w.ev_set;
      done_nxt = 1'b0;
      case (state_r)
         ST_RUN: begin
            if (w.wait_ev_go) begin
               if (event_r) begin
                  event_nxt = w.ev_set;
                  done_nxt = 1'b1;
               end else begin
                  state_nxt = ST_WAIT_EV;
               end
            end else if (w.wait_int_go) begin
               state_nxt = ST_WAIT_INT;
            end
         end
         ST_WAIT_EV: begin
            // An event that wakes the wait is consumed by it
            event_nxt = event_r;
            if (w.wake_ev) begin
               state_nxt = ST_RUN;
               done_nxt = 1'b1;
            end
         end
         default: begin
            if (w.wake_int) begin
               state_nxt = ST_RUN;
               done_nxt = 1'b1;
            end
         end
      endcase
   end

   // State registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_r <= ST_RUN;
         event_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         event_r <= event_nxt;
         done_r <= done_nxt;
      end
   end

   assign w.done = done_r;
   assign w.sleeping = (state_r != ST_RUN);
   assign w.event_reg = event_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_ev_block;
      state_r == ST_RUN && w.wait_ev_go && !event_r;
   endsequence
   sequence s_resumed;
      !w.sleeping && w.done;
   endsequence

   property p_ev_suspend;
      s_ev_block |=> w.sleeping && !w.done;
   endproperty
   a_ev_suspend: assert property (p_ev_suspend) else $error("event wait did not suspend");

   property p_ev_wake;
      state_r == ST_WAIT_EV && w.wake_ev |=> s_resumed;
   endproperty
   a_ev_wake: assert property (p_ev_wake) else $error("event wait missed wake");

   property p_ev_immediate;
      state_r == ST_RUN && w.wait_ev_go && event_r && !w.ev_set |=> (!event_r) and s_resumed;
   endproperty
   a_ev_immediate: assert property (p_ev_immediate) else $error("event wait not immediate");

   property p_int_wake;
      state_r == ST_WAIT_INT && w.wake_int |=> s_resumed;
   endproperty
   a_int_wake: assert property (p_int_wake) else $error("interrupt wait missed wake");

   property p_int_hold;
      state_r == ST_WAIT_INT && !w.wake_int |=> w.sleeping && !w.done;
   endproperty
   a_int_hold: assert property (p_int_hold) else $error("interrupt wait left early");
endmodule

/* dv/tb.sv */
// Self-checking bench for the special register and hint executor.
// Assumes zero-wait APB and one instruction retired at a time.
`timescale 1ns/100ps
module tb;
   // One table row: instruction fields beside the results they should give
   typedef struct packed {
      sr_pkg::op_e op;
      sr_pkg::sel_e sel;
      logic [1:0] am;
      logic pv;
      logic [31:0] src;
      logic [31:0] rd;
      logic [7:0] base;
      logic [4:0] fl;
   } row_s;
   logic clk = 1'b0; // Core clock
   logic rst_b = 1'b0; // Active low reset
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd_data, apb_rd;
   logic pready, pslverr, irq, instr_ready, instr_done, event_out, super_call, suspended, imask, fmask, err;
   logic instr_valid = 1'b0, instr_priv = 1'b0;
   sr_pkg::op_e instr_op = sr_pkg::OP_NOP;
   sr_pkg::sel_e instr_sel = sr_pkg::SEL_APP;
   logic [1:0] instr_app_mask = 2'h0;
   logic [31:0] instr_src = 32'h0;
   logic [5:0] wake = 6'h0; // Wake inputs, one bit each
   logic [4:0] cond_flags;
   logic [7:0] base_priority_mask;
   logic ev, sc; // Pulses caught at retirement
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;
   // Ordinary cases; rd_data holds across non-read rows
   row_s rows [19] = '{
      '{sr_pkg::OP_WRITE_SR, sr_pkg::SEL_BASE, 2'h0, 1'b1, 32'h40, 32'h0, 8'h40, 5'h0},
      '{sr_pkg::OP_READ_SR, sr_pkg::SEL_BASE_RAISE, 2'h0, 1'b1, 32'h0, 32'h40, 8'h40, 5'h0},
      '{sr_pkg::OP_WRITE_SR, sr_pkg::SEL_BASE_RAISE, 2'h0, 1'b1, 32'h30, 32'h40, 8'h30, 5'h0},
      '{sr_pkg::OP_WRITE_SR, sr_pkg::SEL_BASE_RAISE, 2'h0, 1'b1, 32'h38, 32'h40, 8'h30, 5'h0},
      '{sr_pkg::OP_WRITE_SR, sr_pkg::SEL_BASE_RAISE, 2'h0, 1'b1, 32'h0, 32'h40, 8'h30, 5'h0},
      '{sr_pkg::OP_WRITE_SR, sr_pkg::SEL_BASE, 2'h0, 1'b1, 32'h0, 32'h40, 8'h0, 5'h0},
      '{sr_pkg::OP_WRITE_SR, sr_pkg::SEL_BASE_RAISE, 2'h0, 1'b1, 32'h50, 32'h40, 8'h50, 5'h0},
      '{sr_pkg::OP_WRITE_SR, sr_pkg::SEL_BASE, 2'h0, 1'b0, 32'h10, 32'h40, 8'h50, 5'h0},
      '{sr_pkg::OP_WRITE_SR, sr_pkg::SEL_APP, 2'h1, 1'b0, 32'hffffffff, 32'h40, 8'h50, 5'h1f},
      '{sr_pkg::OP_READ_SR, sr_pkg::SEL_ALL, 2'h0, 1'b1, 32'h0, 32'hf8000000, 8'h50, 5'h1f},
      '{sr_pkg::OP_WRITE_SR, sr_pkg::SEL_APP, 2'h1, 1'b1, 32'h50000000, 32'hf8000000, 8'h50, 5'h0a},
      '{sr_pkg::OP_NOP, sr_pkg::SEL_BASE, 2'h0, 1'b1, 32'h7, 32'hf8000000, 8'h50, 5'h0a},
      '{sr_pkg::OP_WRITE_SR, sr_pkg::SEL_PROC_SP, 2'h0, 1'b1, 32'h1237, 32'hf8000000, 8'h50, 5'h0a},
      '{sr_pkg::OP_READ_SR, sr_pkg::SEL_PROC_SP, 2'h0, 1'b1, 32'h0, 32'h1234, 8'h50, 5'h0a},
      '{sr_pkg::OP_WRITE_SR, sr_pkg::SEL_CONTROL, 2'h0, 1'b1, 32'h3, 32'h1234, 8'h50, 5'h0a},
      '{sr_pkg::OP_READ_SR, sr_pkg::SEL_CONTROL, 2'h0, 1'b1, 32'h0, 32'h3, 8'h50, 5'h0a},
      '{sr_pkg::OP_WRITE_SR, sr_pkg::SEL_CONTROL, 2'h0, 1'b1, 32'h0, 32'h3, 8'h50, 5'h0a},
      '{sr_pkg::OP_WRITE_SR, sr_pkg::SEL_APP, 2'h2, 1'b1, 32'h000f0000, 32'h3, 8'h50, 5'h0a},
      '{sr_pkg::OP_READ_SR, sr_pkg::SEL_APP, 2'h0, 1'b1, 32'h0, 32'h500f0000, 8'h50, 5'h0a}};
   // Clock, half period 25 ns
   always #25 clk = ~clk;
   special_reg_and_hint_exec DUT (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .irq, .instr_valid, .instr_ready, .instr_op, .instr_sel, .instr_app_mask, .instr_priv,
      .instr_src, .instr_done, .rd_data, .event_out, .super_call, .suspended, .exc_above_prio(wake[4]),
      .pend_new(wake[5]), .debug_req(wake[2]), .ext_event(wake[0]), .irq_taken(wake[1]),
      .masked_pending(wake[3]), .cond_flags, .interrupt_mask_bit(imask), .base_priority_mask,
      .fault_mask(fmask));
   // Compare and count
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   // One APB transfer; holds the request until pready is seen
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      apb_rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   // Offer one instruction until accepted
   task automatic issue(input sr_pkg::op_e op, input sr_pkg::sel_e sel, input logic [1:0] am, input logic pv,
                        input logic [31:0] src);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr_op <= op;
      instr_sel <= sel;
      instr_app_mask <= am;
      instr_priv <= pv;
      instr_src <= src;
      do @(posedge clk); while (instr_ready !== 1'b1);
      instr_valid <= 1'b0;
   endtask
   // Wait for retirement; the bench timeout bounds it
   task automatic retire;
      #1;
      while (instr_done !== 1'b1) begin
         @(posedge clk);
         #1;
      end
      ev = event_out;
      sc = super_call;
   endtask
   // Suspend, offer a pulse that must not wake, then a real wake source
   task automatic doze(input sr_pkg::op_e op, input logic [5:0] first, input int k);
      issue(op, sr_pkg::SEL_APP, 2'h0, 1'b1, 32'h0);
      @(posedge clk);
      wake <= first;
      @(posedge clk);
      wake <= 6'h0;
      @(posedge clk);
      wake <= 6'h1 << k;
      #1;
      check("asleep", 32'({suspended, instr_ready}), 32'h2);
      @(posedge clk);
      wake <= 6'h0;
      retire();
      check("woken", 32'({suspended, base_priority_mask}), 32'h50);
      $display("wait test %0d done", k);
   endtask
   // Verdict and end of run
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Hang guard, well above the hundred and twenty or so cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         give_verdict();
      end
   end
   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      #1;
      check("reset outs", 32'({pready, instr_ready, irq, suspended, instr_done, imask, fmask}), 32'h60);
      apb(1'b0, sr_pkg::ADDR_IRQ_MASK, 32'h0);
      check("mask reset", apb_rd, 32'h0);
      $display("reset test done");
      foreach (rows[i]) begin
         issue(rows[i].op, rows[i].sel, rows[i].am, rows[i].pv, rows[i].src);
         retire();
         check("rd_data", rd_data, rows[i].rd);
         check("base", 32'(base_priority_mask), 32'(rows[i].base));
         check("flags", 32'(cond_flags), 32'(rows[i].fl));
      end
      $display("table test done");
      apb(1'b0, sr_pkg::ADDR_IRQ_ST, 32'h0);
      check("refused", apb_rd, 32'h8);
      apb(1'b1, sr_pkg::ADDR_IRQ_ST, 32'hf);
      issue(sr_pkg::OP_SEND_EVENT, sr_pkg::SEL_APP, 2'h0, 1'b1, 32'h0);
      retire();
      check("event out", 32'(ev), 32'h1);
      apb(1'b0, sr_pkg::ADDR_STATE, 32'h0);
      check("event reg", apb_rd, 32'h5002);
      issue(sr_pkg::OP_WAIT_EVENT, sr_pkg::SEL_APP, 2'h0, 1'b1, 32'h0);
      retire();
      apb(1'b0, sr_pkg::ADDR_STATE, 32'h0);
      check("event clear", apb_rd, 32'h5000);
      $display("event test done");
      doze(sr_pkg::OP_WAIT_EVENT, 6'h20, 0);
      apb(1'b1, sr_pkg::ADDR_CTRL, 32'h3);
      doze(sr_pkg::OP_WAIT_EVENT, 6'h0, 5);
      doze(sr_pkg::OP_WAIT_EVENT, 6'h0, 4);
      doze(sr_pkg::OP_WAIT_EVENT, 6'h0, 2);
      doze(sr_pkg::OP_WAIT_INT, 6'h01, 1);
      doze(sr_pkg::OP_WAIT_INT, 6'h0, 3);
      doze(sr_pkg::OP_WAIT_INT, 6'h0, 2);
      apb(1'b1, sr_pkg::ADDR_IRQ_ST, 32'hf);
      apb(1'b1, sr_pkg::ADDR_IRQ_MASK, 32'h1);
      issue(sr_pkg::OP_SUPER_CALL, sr_pkg::SEL_APP, 2'h0, 1'b0, 32'h0);
      retire();
      check("call", 32'({sc, ev}), 32'h2);
      apb(1'b0, sr_pkg::ADDR_IRQ_ST, 32'h0);
      check("call status", 32'({irq, apb_rd[3:0]}), 32'h11);
      apb(1'b1, sr_pkg::ADDR_IRQ_MASK, 32'h0);
      check("masked", 32'(irq), 32'h0);
      apb(1'b1, sr_pkg::ADDR_IRQ_MASK, 32'h1);
      apb(1'b1, sr_pkg::ADDR_IRQ_ST, 32'h1);
      check("cleared", 32'(irq), 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      check("slverr", 32'(err), 32'h1);
      check("unmapped", apb_rd, 32'h0);
      $display("interrupt test done");
      give_verdict();
   end
endmodule
